//--- design/echo_canceller_group_control.sv
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// one disable-tone detector; tone, reversal and quiet inputs come from the analysis core on pclk, plain_mode from CR2
module tone_detector #(
  parameter int PLAIN_FR = 3200,
  parameter int PHASE_FR = 8000,
  parameter int REL_FR = 3200,
  parameter int CW = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_tick,
  input wire logic tone_present,
  input wire logic phase_reversal,
  input wire logic quiet,
  input wire logic plain_mode,
  output logic flag,
  output logic detect,
  output logic release_ev
);
  typedef enum logic [1:0] {IDLE, TONE, HELD} tstate_e;
  tstate_e state_q;
  logic [CW-1:0] cnt_q;
  logic rev_q;
  logic met;

  // plain mode ignores reversals; phase mode needs one plus the long run
  assign met = plain_mode ? (cnt_q >= CW'(PLAIN_FR - 1))
             : (cnt_q >= CW'(PHASE_FR - 1)) && rev_q;

  // state and duration count, advanced once per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        IDLE: begin
          cnt_q <= '0;
          if (frame_tick && tone_present) begin
            state_q <= TONE;
          end
        end
        TONE: begin
          if (frame_tick) begin
            if (!tone_present) begin
              state_q <= IDLE;
            end else if (met) begin
              state_q <= HELD;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        HELD: begin
          // held without tone; any loud frame restarts the quiet run
          if (frame_tick) begin
            if (!quiet) begin
              cnt_q <= '0;
            end else if (cnt_q >= CW'(REL_FR - 1)) begin
              state_q <= IDLE;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // reversal seen during the current tone run; pulses may fall between ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_q <= 1'b0;
    end else if (state_q != TONE) begin
      rev_q <= 1'b0;
    end else if (phase_reversal) begin
      rev_q <= 1'b1;
    end
  end

  assign flag = (state_q == HELD);
  assign detect = (state_q == TONE) && frame_tick && tone_present && met;
  assign release_ev = (state_q == HELD) && frame_tick && quiet
                      && (cnt_q >= CW'(REL_FR - 1));
endmodule : tone_detector

////////////////////////////////////////////////////////////////////////////////
module echo_canceller_group_control #(
  parameter int PLAIN_FRAMES = ecg_pkg::PLAIN_FR,
  parameter int PHASE_FRAMES = ecg_pkg::PHASE_FR,
  parameter int RELEASE_FRAMES = ecg_pkg::RELEASE_FR
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_tick,
  input wire ecg_pkg::pcm_s [1:0] pcm_in,
  input wire ecg_pkg::pcm_s [1:0] core_out,
  input wire logic [3:0] tone_present,
  input wire logic [3:0] phase_reversal,
  input wire logic [3:0] quiet_level,
  input wire logic [1:0] narrowband_present,
  output ecg_pkg::ctrl_s [1:0] ctrl,
  output ecg_pkg::pcm_s [1:0] pcm_out,
  output logic irq_n
);
  import ecg_pkg::*;

  logic [7:0] cr1_q [2];
  logic [7:0] cr2_q [2];
  logic [7:0] cr3_q [2];
  logic [7:0] nscl_q [2];
  logic [3:0] ninc_q [2];
  logic [15:0] gain_q [2];
  logic [3:0] flag;
  logic [3:0] det;
  logic [3:0] rel;
  logic irq_pend_q;
  logic [IDX_W-1:0] idx;
  logic sel_b;
  logic [4:0] reg_idx;
  logic mapped;
  logic wr_en;
  logic rd_setup;
  logic [31:0] rd_d;
  logic ext_mode;
  logic btb_mode;
  logic [1:0] byp;
  logic [15:0] quiet [2];

  //////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, unaligned or unmapped gives pslverr
  assign idx = paddr[7:2];
  assign sel_b = idx[B_SEL_BIT];
  assign reg_idx = idx[4:0];
  always_comb begin
    case (reg_idx)
      REG_CR1, REG_CR2, REG_STAT, REG_CR3,
      REG_NSCL, REG_NCTL, REG_GAIN: mapped = (paddr[1:0] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;

  // read data captured in setup so it is a flop by the access phase
  always_comb begin
    rd_d = 32'h0000_0000;
    case (reg_idx)
      REG_CR1: rd_d[7:0] = cr1_q[sel_b];
      REG_CR2: rd_d[7:0] = cr2_q[sel_b];
      REG_STAT: begin
        rd_d[ST_FLAG] = flag[2*sel_b] | flag[2*sel_b+1];
        rd_d[ST_RIN] = flag[2*sel_b];
        rd_d[ST_SIN] = flag[2*sel_b+1];
      end
      REG_CR3: rd_d[7:0] = cr3_q[sel_b];
      REG_NSCL: rd_d[7:0] = nscl_q[sel_b];
      REG_NCTL: rd_d[3:0] = ninc_q[sel_b];
      REG_GAIN: rd_d[15:0] = gain_q[sel_b];
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= mapped ? rd_d : 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers, one set per canceller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        cr1_q[c] <= CR1_RST;
        cr2_q[c] <= CR2_RST;
        cr3_q[c] <= CR3_RST;
        nscl_q[c] <= NSCL_RST;
        ninc_q[c] <= NINC_RST;
        gain_q[c] <= GAIN_RST;
      end
    end else if (wr_en) begin
      case (reg_idx)
        // canceller_b has no extended delay bit; it always reads zero
        REG_CR1: begin
          cr1_q[sel_b] <= pwdata[7:0];
          if (sel_b) begin
            cr1_q[1][CR1_EXT] <= 1'b0;
          end
        end
        REG_CR2: cr2_q[sel_b] <= pwdata[7:0];
        REG_CR3: cr3_q[sel_b] <= pwdata[7:0];
        REG_NSCL: nscl_q[sel_b] <= pwdata[7:0];
        REG_NCTL: ninc_q[sel_b] <= pwdata[3:0];
        REG_GAIN: gain_q[sel_b] <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // four tone detectors: index 2*canceller + 0 receive, + 1 send
  for (genvar i = 0; i < 4; i++) begin : g_td
    tone_detector #(
      .PLAIN_FR(PLAIN_FRAMES),
      .PHASE_FR(PHASE_FRAMES),
      .REL_FR(RELEASE_FRAMES),
      .CW(14)
    ) u_td (
      .pclk(pclk),
      .presetn(presetn),
      .frame_tick(frame_tick),
      .tone_present(tone_present[i]),
      .phase_reversal(phase_reversal[i]),
      .quiet(quiet_level[2*(i/2)] && quiet_level[2*(i/2)+1]),
      .plain_mode(cr2_q[i/2][CR2_PHASE_CHECK_DISABLE]),
      .flag(flag[i]),
      .detect(det[i]),
      .release_ev(rel[i])
    );
  end

  // interrupt pending until a status read; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_q <= 1'b0;
    end else if (|det || |rel) begin
      irq_pend_q <= 1'b1;
    end else if (psel && penable && !pwrite && reg_idx == REG_STAT) begin
      irq_pend_q <= 1'b0;
    end
  end
  assign irq_n = !irq_pend_q;

  //////////////////////////////////////////////////////////////////////////////
  // group configuration and per-canceller functional state
  assign ext_mode = cr1_q[0][CR1_EXT];
  assign btb_mode = cr1_q[0][CR1_BTB] && cr1_q[1][CR1_BTB];

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // host bypass, or detector bypass when automatic mode is on
      byp[c] = cr1_q[c][CR1_BYP]
             || (cr2_q[c][CR2_AUTO] && (flag[2*c] || flag[2*c+1]));
      case (cr2_q[c][CR2_FMT+:2])
        FMT_LIN: quiet[c] = QUIET_LIN;
        FMT_SM: quiet[c] = QUIET_SM;
        FMT_MU: quiet[c] = QUIET_MU;
        FMT_A: quiet[c] = QUIET_A;
        default: quiet[c] = QUIET_LIN;
      endcase
    end
  end

  // control bundle to the filter core
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      ctrl[c].suppressor_select = cr3_q[c][CR3_SEL];
      ctrl[c].injection_control = cr3_q[c][CR3_INJ];
      ctrl[c].ramp_increment = ninc_q[c];
      ctrl[c].noise_scaling = nscl_q[c];
      ctrl[c].echo_noise_guard = cr3_q[c][CR3_G1];
      ctrl[c].doubletalk_noise_guard = cr3_q[c][CR3_G2];
      ctrl[c].ring_clear = cr3_q[c][CR3_RING];
      // narrowband detector runs in every state unless disabled
      ctrl[c].narrowband_enable = !cr2_q[c][CR2_NARROWBAND_DISABLE];
      ctrl[c].highpass_enable = !cr2_q[c][CR2_HPDIS];
      ctrl[c].adapt_enable = !byp[c] && !cr1_q[c][CR1_ADIS]
        && !(narrowband_present[c] && !cr2_q[c][CR2_NARROWBAND_DISABLE]);
      ctrl[c].coef_clear = byp[c];
      // b follows a as one 128 ms tail; else parallel 64 ms each
      ctrl[c].cascade = ext_mode;
      ctrl[c].back_to_back = btb_mode;
      ctrl[c].gain_rin = cr1_q[c][CR1_PAD] ? GAIN_M12 : gain_q[c][2:0];
      ctrl[c].gain_rout = gain_q[c][6:4];
      ctrl[c].gain_sin = gain_q[c][10:8];
      ctrl[c].gain_sout = gain_q[c][14:12];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output samples, updated once per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_out <= '0;
    end else if (frame_tick) begin
      for (int c = 0; c < 2; c++) begin
        if (c == 1 && (ext_mode || btb_mode)) begin
          // canceller_b timeslot is unused in the combined modes
          pcm_out[c].rcv <= quiet[0];
          pcm_out[c].snd <= quiet[0];
        end else if (byp[c]) begin
          pcm_out[c] <= pcm_in[c];
        end else begin
          pcm_out[c] <= core_out[c];
        end
      end
    end
  end
endmodule : echo_canceller_group_control

//--- design/ecg_pkg.sv
package ecg_pkg;
  // register indices; byte address is four times the index
  localparam int IDX_W = 6;
  localparam logic [4:0] REG_CR1 = 5'h00;
  localparam logic [4:0] REG_CR2 = 5'h01;
  localparam logic [4:0] REG_STAT = 5'h02;
  localparam logic [4:0] REG_CR3 = 5'h08;
  localparam logic [4:0] REG_NSCL = 5'h0A;
  localparam logic [4:0] REG_NCTL = 5'h0B;
  localparam logic [4:0] REG_GAIN = 5'h1C;
  localparam int B_SEL_BIT = 5; // index bit that selects canceller_b
  // control register 1 fields
  localparam int CR1_EXT = 0;
  localparam int CR1_BTB = 1;
  localparam int CR1_PAD = 2;
  localparam int CR1_BYP = 3;
  localparam int CR1_ADIS = 4;
  // control register 2 fields
  localparam int CR2_PHASE_CHECK_DISABLE = 0;
  localparam int CR2_AUTO = 1;
  localparam int CR2_NARROWBAND_DISABLE = 2;
  localparam int CR2_HPDIS = 3;
  localparam int CR2_FMT = 4; // two bits: pcm coding
  // control register 3 fields
  localparam int CR3_SEL = 0;
  localparam int CR3_INJ = 1;
  localparam int CR3_G1 = 2;
  localparam int CR3_G2 = 3;
  localparam int CR3_RING = 4;
  // status fields
  localparam int ST_FLAG = 0;
  localparam int ST_RIN = 1;
  localparam int ST_SIN = 2;
  // reset values
  localparam logic [7:0] CR1_RST = 8'h00;
  localparam logic [7:0] CR2_RST = 8'h00;
  localparam logic [7:0] CR3_RST = 8'h0F;
  localparam logic [7:0] NSCL_RST = 8'h16;
  localparam logic [3:0] NINC_RST = 4'h5;
  localparam logic [2:0] GAIN_0DB = 3'h3; // codes 0..7 = +9..-12 dB
  localparam logic [2:0] GAIN_M12 = 3'h7;
  localparam logic [15:0] GAIN_RST = 16'h3333;
  // pcm coding and quiet code
  localparam logic [1:0] FMT_LIN = 2'h0;
  localparam logic [1:0] FMT_SM = 2'h1;
  localparam logic [1:0] FMT_MU = 2'h2;
  localparam logic [1:0] FMT_A = 2'h3;
  localparam logic [15:0] QUIET_LIN = 16'h0000;
  localparam logic [15:0] QUIET_SM = 16'h0080;
  localparam logic [15:0] QUIET_MU = 16'h00FF;
  localparam logic [15:0] QUIET_A = 16'h00D5;
  // tone timing, in frames of the 8 kHz frame tick
  localparam int FRAME_HZ = 8000;
  localparam int PLAIN_MS = 400;
  localparam int PHASE_MS = 1000;
  localparam int RELEASE_MS = 400;
  localparam int PLAIN_FR = PLAIN_MS * FRAME_HZ / 1000;
  localparam int PHASE_FR = PHASE_MS * FRAME_HZ / 1000;
  localparam int RELEASE_FR = RELEASE_MS * FRAME_HZ / 1000;

  typedef struct packed {
    logic [15:0] rcv; // receive direction sample
    logic [15:0] snd; // send direction sample
  } pcm_s;

  typedef struct packed {
    logic suppressor_select;
    logic injection_control;
    logic [3:0] ramp_increment;
    logic [7:0] noise_scaling;
    logic echo_noise_guard;
    logic doubletalk_noise_guard;
    logic ring_clear;
    logic narrowband_enable;
    logic highpass_enable;
    logic adapt_enable;
    logic coef_clear;
    logic cascade;
    logic back_to_back;
    logic [2:0] gain_rin;
    logic [2:0] gain_rout;
    logic [2:0] gain_sin;
    logic [2:0] gain_sout;
  } ctrl_s;
endpackage : ecg_pkg

//--- sim/tdm_far_end.sv
`timescale 1ns/1ps
module tdm_far_end #(
  parameter int TICK_CYC = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] tone_cmd,
  input wire logic [3:0] rev_cmd,
  input wire logic nb_cmd,
  output logic frame_tick,
  output logic [3:0] tone_present,
  output logic [3:0] phase_reversal,
  output logic [3:0] quiet_level,
  output logic [1:0] narrowband_present,
  output ecg_pkg::pcm_s [1:0] pcm_in,
  output ecg_pkg::pcm_s [1:0] core_out
);
  import ecg_pkg::*;
  logic [7:0] cyc_q;
  logic [15:0] fr_q;
  // frame divider; samples move on every frame so stale data shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q <= 8'h00;
      fr_q <= 16'h0000;
    end else if (cyc_q == 8'(TICK_CYC - 1)) begin
      cyc_q <= 8'h00;
      fr_q <= fr_q + 16'h0001;
    end else begin
      cyc_q <= cyc_q + 8'h01;
    end
  end
  // reversal pulse lands mid-frame, away from the tick
  assign frame_tick = (cyc_q == 8'(TICK_CYC - 1));
  assign phase_reversal = (cyc_q == 8'h03) ? rev_cmd : 4'h0;
  assign tone_present = tone_cmd;
  assign quiet_level = ~tone_cmd; // a silent input is under both thresholds
  assign narrowband_present = {2{nb_cmd}};
  // inputs and core results carry distinct patterns
  assign pcm_in[0] = {fr_q, ~fr_q};
  assign pcm_in[1] = {fr_q ^ 16'h5A5A, fr_q + 16'h0100};
  assign core_out[0] = {~fr_q, fr_q ^ 16'h00F0};
  assign core_out[1] = {fr_q + 16'h0777, fr_q ^ 16'hC3C3};
endmodule : tdm_far_end

//--- sim/ecg_monitor.sv
`timescale 1ns/1ps
module ecg_monitor #(
  parameter int PLAIN_FRAMES = 4,
  parameter int PHASE_FRAMES = 10,
  parameter int RELEASE_FRAMES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_tick,
  input wire ecg_pkg::pcm_s [1:0] pcm_in,
  input wire ecg_pkg::pcm_s [1:0] core_out,
  input wire logic [1:0] narrowband_present,
  input wire ecg_pkg::ctrl_s [1:0] ctrl,
  input wire ecg_pkg::pcm_s [1:0] pcm_out,
  input wire logic irq_n
);
  import ecg_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus access phase, and a status read of either canceller
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_stat_rd;
    s_acc ##0 (!pwrite && paddr[6:0] == 7'h08);
  endsequence
  property p_ready; s_acc |-> pready; endproperty
  property p_err_idle; !(psel && penable) |-> !pslverr; endproperty
  property p_err_unal; s_acc ##0 paddr[1:0] != 2'h0 |-> pslverr; endproperty
  property p_err_map; s_acc ##0 paddr == 8'h00 |-> !pslverr; endproperty
  property p_hold; !frame_tick |=> $stable(pcm_out); endproperty
  property p_byp;
    frame_tick && ctrl[0].coef_clear |=> pcm_out[0] == $past(pcm_in[0]);
  endproperty
  property p_norm;
    frame_tick && !ctrl[0].coef_clear |=> pcm_out[0] == $past(core_out[0]);
  endproperty
  property p_nb;
    ctrl[0].narrowband_enable && narrowband_present[0] |->
      !ctrl[0].adapt_enable;
  endproperty
  property p_irq_ev;
    $fell(irq_n) |-> $past(frame_tick) || $past(frame_tick, 2);
  endproperty
  // a read clears the request unless a fresh event is in flight
  property p_irq_clr;
    s_stat_rd ##0 (!frame_tick && !$past(frame_tick) &&
      !$past(frame_tick, 2)) |=> irq_n;
  endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  a_err_idle: assert property (p_err_idle) else $error("error outside access");
  a_err_unal: assert property (p_err_unal) else $error("unaligned not refused");
  a_err_map: assert property (p_err_map) else $error("mapped access refused");
  a_hold: assert property (p_hold) else $error("samples moved off tick");
  a_byp: assert property (p_byp) else $error("bypass altered codes");
  a_norm: assert property (p_norm) else $error("core result lost");
  a_nb: assert property (p_nb) else $error("adapting on tones");
  a_irq_ev: assert property (p_irq_ev) else $error("stray request");
  a_irq_clr: assert property (p_irq_clr) else $error("request kept");
endmodule : ecg_monitor
bind echo_canceller_group_control ecg_monitor #(
  .PLAIN_FRAMES(PLAIN_FRAMES), .PHASE_FRAMES(PHASE_FRAMES),
  .RELEASE_FRAMES(RELEASE_FRAMES)
) ecg_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .frame_tick(frame_tick), .pcm_in(pcm_in), .core_out(core_out),
  .narrowband_present(narrowband_present), .ctrl(ctrl),
  .pcm_out(pcm_out), .irq_n(irq_n)
);

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ecg_pkg::*;
  localparam int LIMIT = 20000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic frame_tick, irq_n, nb_cmd;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] tone_present, phase_reversal, quiet_level, tone_cmd, rev_cmd;
  logic [1:0] narrowband_present;
  logic [15:0] qt [4] = '{QUIET_LIN, QUIET_SM, QUIET_MU, QUIET_A};
  pcm_s [1:0] pcm_in, core_out, pcm_out;
  ctrl_s [1:0] ctrl;
  int error_cnt = 0, compares = 0, cyc = 0;
  tdm_far_end tdm_far_end_inst (.pclk(pclk), .presetn(presetn),
    .tone_cmd(tone_cmd), .rev_cmd(rev_cmd), .nb_cmd(nb_cmd),
    .frame_tick(frame_tick), .tone_present(tone_present),
    .phase_reversal(phase_reversal), .quiet_level(quiet_level),
    .narrowband_present(narrowband_present), .pcm_in(pcm_in),
    .core_out(core_out));
  // short counts keep the tone scenarios to a few hundred cycles
  echo_canceller_group_control #(.PLAIN_FRAMES(4), .PHASE_FRAMES(10),
    .RELEASE_FRAMES(4)) echo_canceller_group_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_tick(frame_tick),
    .pcm_in(pcm_in), .core_out(core_out), .tone_present(tone_present),
    .phase_reversal(phase_reversal), .quiet_level(quiet_level),
    .narrowband_present(narrowband_present), .ctrl(ctrl),
    .pcm_out(pcm_out), .irq_n(irq_n));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] ad(input logic b, input logic [4:0] i);
    return {b, i, 2'b00};
  endfunction : ad
  // one transfer; waits for ready, never assumes the wait length
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk iff frame_tick);
    @(posedge pclk);
  endtask : ticks
  function automatic logic [31:0] fa(input ctrl_s c);
    return {29'h0, c.adapt_enable, c.narrowband_enable, c.highpass_enable};
  endfunction : fa
  // suppressor and noise controls, named fields so layout changes are safe
  function automatic logic [31:0] fn(input ctrl_s c);
    return {27'h0, c.suppressor_select, c.injection_control,
            c.echo_noise_guard, c.doubletalk_noise_guard, c.ring_clear};
  endfunction : fn
  // four port gain codes, receive in first
  function automatic logic [31:0] fg(input ctrl_s c);
    return {20'h0, c.gain_rin, c.gain_rout, c.gain_sin, c.gain_sout};
  endfunction : fg
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(ad(0, REG_CR1), {24'h0, CR1_RST});
    rchk(ad(1, REG_CR2), {24'h0, CR2_RST});
    rchk(ad(0, REG_CR3), {24'h0, CR3_RST});
    rchk(ad(1, REG_NSCL), {24'h0, NSCL_RST});
    rchk(ad(0, REG_NCTL), {28'h0, NINC_RST});
    rchk(ad(0, REG_GAIN), {16'h0, GAIN_RST});
    apb(1'b0, 8'h0C, 32'h0);
    chk({rd[30:0], perr}, 32'h1);
    apb(1'b1, 8'h01, 32'hFF);
    chk({31'h0, perr}, 32'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ctrl;
    apb(1'b1, ad(0, REG_CR3), 32'h10);
    chk(fn(ctrl[0]), 32'h01);
    apb(1'b1, ad(0, REG_CR3), 32'h0F);
    chk(fn(ctrl[0]), 32'h1E);
    apb(1'b1, ad(0, REG_NCTL), 32'hA);
    apb(1'b1, ad(0, REG_NSCL), 32'h74);
    chk({20'h0, ctrl[0].ramp_increment, ctrl[0].noise_scaling}, 32'hA74);
    apb(1'b1, ad(1, REG_GAIN), 32'h7654);
    chk(fg(ctrl[1]), 32'h977);
    apb(1'b1, ad(1, REG_CR1), 32'h04);
    chk({29'h0, ctrl[1].gain_rin}, {29'h0, GAIN_M12});
    apb(1'b1, ad(1, REG_CR1), 32'h0);
    nb_cmd <= 1'b1;
    @(posedge pclk);
    chk(fa(ctrl[0]), 32'h3);
    apb(1'b1, ad(0, REG_CR2), 32'h0C);
    chk(fa(ctrl[0]), 32'h4);
    apb(1'b1, ad(0, REG_CR2), 32'h0);
    nb_cmd <= 1'b0;
    $display("test controls done");
  endtask : t_ctrl
  task automatic t_plain;
    apb(1'b1, ad(0, REG_CR2), 32'h03);
    tone_cmd <= 4'h1;
    ticks(6);
    chk({30'h0, irq_n, ctrl[0].coef_clear}, 32'h1);
    rchk(ad(0, REG_STAT), 32'h3);
    chk({31'h0, irq_n}, 32'h1);
    tone_cmd <= 4'h0;
    ticks(2);
    rchk(ad(0, REG_STAT), 32'h3);
    ticks(4);
    chk({31'h0, irq_n}, 32'h0);
    rchk(ad(0, REG_STAT), 32'h0);
    chk({31'h0, ctrl[0].coef_clear}, 32'h0);
    apb(1'b1, ad(0, REG_CR2), 32'h0);
    $display("test plain tone done");
  endtask : t_plain
  task automatic t_phase;
    tone_cmd <= 4'h8;
    ticks(12);
    rchk(ad(1, REG_STAT), 32'h0);
    tone_cmd <= 4'h0;
    ticks(1);
    tone_cmd <= 4'h8;
    rev_cmd <= 4'h8;
    ticks(2);
    rev_cmd <= 4'h0;
    ticks(10);
    chk({31'h0, irq_n}, 32'h0);
    rchk(ad(1, REG_STAT), 32'h5);
    apb(1'b1, ad(1, REG_CR1), 32'h08);
    chk({31'h0, ctrl[1].coef_clear}, 32'h1);
    tone_cmd <= 4'h0;
    ticks(6);
    rchk(ad(1, REG_STAT), 32'h0);
    apb(1'b1, ad(1, REG_CR1), 32'h0);
    $display("test phase tone done");
  endtask : t_phase
  task automatic t_config;
    apb(1'b1, ad(1, REG_CR1), 32'h0);
    apb(1'b1, ad(0, REG_CR1), 32'h01);
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, ad(0, REG_CR2), 32'(f) << 4);
      ticks(1);
      chk(pcm_out[1], {qt[f], qt[f]});
    end
    chk({31'h0, ctrl[0].cascade}, 32'h1);
    apb(1'b1, ad(0, REG_CR1), 32'h02);
    apb(1'b1, ad(1, REG_CR1), 32'h02);
    ticks(1);
    chk(pcm_out[1], {qt[3], qt[3]});
    chk({31'h0, ctrl[0].back_to_back}, 32'h1);
    apb(1'b1, ad(0, REG_CR1), 32'h0);
    apb(1'b1, ad(1, REG_CR1), 32'h0);
    $display("test configurations done");
  endtask : t_config
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, nb_cmd, presetn} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tone_cmd = 4'h0;
    rev_cmd = 4'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_ctrl();
    t_plain();
    t_phase();
    t_config();
    complete_run();
  end
endmodule : testbench
